// ==== verilog/wwdt_consts.svh ====
// Offsets, field positions, reset values and counts of the windowed watchdog
`ifndef WWDT_CONSTS_SVH
`define WWDT_CONSTS_SVH

// =====================================================================
// Register byte offsets
`define WWDT_OFS_CONTROL   8'h00
`define WWDT_OFS_MODE      8'h04
`define WWDT_OFS_STATUS    8'h08
`define WWDT_ADDR_BITS     8

// =====================================================================
// Control register fields
`define WWDT_KEY_HI        31
`define WWDT_KEY_LO        24
`define WWDT_KEY_VALUE     8'ha5
`define WWDT_RESTART_BIT   0

// =====================================================================
// Status register fields
`define WWDT_UNF_BIT       0
`define WWDT_ERR_BIT       1

// =====================================================================
// Reset values
`define WWDT_MODE_RESET    32'h3fff2fff
`define WWDT_LOAD_RESET    12'hfff

// =====================================================================
// Counter and prescaler
`define WWDT_CNT_W         12
`define WWDT_PRE_W         7
`define WWDT_PRE_LAST      7'h7f

// =====================================================================
// AHB-Lite encodings
`define WWDT_HTRANS_NONSEQ 2'h2
`define WWDT_HTRANS_SEQ    2'h3
`define WWDT_HSIZE_WORD    3'h2

`endif

// ==== verilog/wwdt_pkg.sv ====
// Types shared by the windowed watchdog design
package wwdt_pkg;

    // =================================================================
    // Mode register layout, msb first
    typedef struct packed {
        logic [1:0]  reserved;               // Read as written, unused
        logic        idle_halt;              // Stop counting in idle mode
        logic        debug_halt;             // Stop counting in debug state
        logic [11:0] restart_window_delta;   // Upper edge of restart window
        logic        timer_disable;          // Stops counting
        logic        processor_only_reset;   // Fault resets processor only
        logic        fault_reset_enable;     // Fault requests a reset
        logic        fault_interrupt_enable; // Flags request an interrupt
        logic [11:0] counter_load_field;     // Value loaded into the counter
    } wwdt_mode_t;

    // Latched AHB address phase
    typedef struct packed {
        logic       valid;                   // A transfer is in data phase
        logic       write;                   // Direction of that transfer
        logic [7:0] addr;                    // Byte offset inside the block
    } wwdt_aphase_t;

    // Synchronised pin inputs
    typedef struct packed {
        logic slow_clk;                      // Slow clock level
        logic debug;                         // Processor in debug state
        logic idle;                          // System in idle mode
    } wwdt_pins_t;

endpackage : wwdt_pkg

// ==== verilog/wwdt_top.sv ====
// Windowed watchdog timer with keyed restart and AHB-Lite registers
`include "wwdt_consts.svh"

// Overview of operation
// - Twelve-bit down counter loaded from mode field
// - Counter steps at slow clock over 128
// - Load field 0xFFF, reset enable set after reset
// - Mode register accepts first write only
// - Mode write reloads and restarts counter
// - Restart reloads counter and clears prescaler
// - Control write needs key 0xA5 in 31:24
// - Restart only when counter within delta window
// - Restart outside window sets error and fault
// - Delta at or above load allows all restarts
// - Underflow sets flag, fault if reset enabled
// - Flags interrupt only when enable bit set
// - Processor-only bit picks reset scope
// - Watchdog reset clears block and flags
// - Status read clears flags, interrupt and fault
// - Debug and idle halt bits stop counter
// - Disable bit stops watchdog counting
// - Status flags stay set until read
module wwdt_top (
    input  wire logic        CLK,          // System clock, 125 MHz
    input  wire logic        RST_N,        // Processor or watchdog reset
    input  wire logic        SLOW_CLK,     // Slow clock, asynchronous
    input  wire logic        DEBUG_STATE,  // Processor in debug, async
    input  wire logic        IDLE_MODE,    // System idle, async
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic [31:0]      HRDATA,
    output logic             FAULT,        // Fault level to reset control
    output logic             FAULT_IRQ,    // Interrupt request
    output logic             RESET_ALL,    // Request for all resets
    output logic             RESET_PROC    // Request for processor reset
);

    // =================================================================
    // Declarations
    wwdt_pkg::wwdt_mode_t   mode;          // Mode register contents
    logic                   mode_locked;   // Mode already written once
    logic [11:0]            count;         // Watchdog down counter
    logic [6:0]             prescale;      // Slow clock divider
    logic                   underflow_flag;
    logic                   window_error_flag;
    wwdt_pkg::wwdt_aphase_t aphase;        // Pending data phase
    wwdt_pkg::wwdt_pins_t   pin_meta;      // First synchroniser stage
    wwdt_pkg::wwdt_pins_t   pin_sync;      // Second synchroniser stage
    logic                   slow_prev;     // Delayed slow clock level
    logic                   slow_tick;     // One cycle per rising slow edge
    logic                   halted;        // Counting suspended
    logic                   div_tick;      // One cycle per 128 slow edges
    logic                   underflow_evt; // Counter passes zero
    logic                   ctrl_write;    // Keyed control write
    logic                   restart_req;   // Keyed restart command
    logic                   restart_ok;    // Restart inside window
    logic                   restart_err;   // Restart outside window
    logic                   mode_write;    // First mode write
    logic                   status_read;   // Status read in address phase
    logic                   addr_take;     // Valid address phase taken
    logic                   fault_set;     // Event that raises the fault
    logic [31:0]            next_rdata;    // Read data for next phase

    // =================================================================
    // Pin synchronisers
    // Two stages per pin; only the second stage feeds logic
    localparam int NPINS = 3;
    wire [NPINS-1:0] pin_raw = {SLOW_CLK, DEBUG_STATE, IDLE_MODE};

    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_sync
            // First stage catches the asynchronous level
            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    pin_meta[gi] <= 1'b0;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                end
            end
            // Second stage is the only one read by logic
            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    pin_sync[gi] <= 1'b0;
                end else begin
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    // Edge detector on the synchronised slow clock
    // Cleared with the synchroniser, so a slow clock already high at release shows as one rising edge
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            slow_prev <= 1'b0;
        end else begin
            slow_prev <= pin_sync.slow_clk;
        end
    end

    assign slow_tick = pin_sync.slow_clk & ~slow_prev;

    // =================================================================
    // Bus decode
    // Every selected transfer is acted upon; HSIZE is not decoded
    assign addr_take = HSEL & HREADY & HTRANS[1];

    // Status read acts in the address phase so the flags read back
    // match the clear that the read performs
    assign status_read = addr_take & ~HWRITE
                       & (HADDR[`WWDT_ADDR_BITS-1:0] == `WWDT_OFS_STATUS);

    // Writes act in the data phase, where HWDATA stands
    assign ctrl_write  = aphase.valid & aphase.write
                       & (aphase.addr == `WWDT_OFS_CONTROL)
                       & (HWDATA[`WWDT_KEY_HI:`WWDT_KEY_LO]
                          == `WWDT_KEY_VALUE);
    assign restart_req = ctrl_write & HWDATA[`WWDT_RESTART_BIT];

    // Window check; a delta at or above the load value opens the
    // whole counter range since the count never exceeds the load
    assign restart_ok  = restart_req
                       & (count <= mode.restart_window_delta);
    assign restart_err = restart_req
                       & (count > mode.restart_window_delta);

    // Mode register takes its first write only
    assign mode_write  = aphase.valid & aphase.write & ~mode_locked
                       & (aphase.addr == `WWDT_OFS_MODE);

    // =================================================================
    // Address phase capture
    // Held while HREADY is low so a stalled address phase is kept
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            aphase <= '0;
        end else if (HREADY) begin
            aphase.valid <= addr_take;
            aphase.write <= HWRITE;
            aphase.addr  <= HADDR[`WWDT_ADDR_BITS-1:0];
        end
    end

    // Slave is never stalled and never errs
    // Low in reset so no transfer is taken before the block is ready
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            HREADYOUT <= 1'b0;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
    end

    // =================================================================
    // Read data, registered for the data phase
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (addr_take && !HWRITE) begin
            case (HADDR[`WWDT_ADDR_BITS-1:0])
                `WWDT_OFS_MODE: begin
                    next_rdata = mode;
                end
                `WWDT_OFS_STATUS: begin
                    next_rdata[`WWDT_UNF_BIT] = underflow_flag;
                    next_rdata[`WWDT_ERR_BIT] = window_error_flag;
                end
                default: begin
                    // Control is write-only; unmapped reads give zero
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            HRDATA <= 32'h0000_0000;
        end else if (HREADY) begin
            HRDATA <= next_rdata;
        end
    end

    // =================================================================
    // Mode register
    // Reset value runs a full-length watchdog with reset enabled
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            mode        <= `WWDT_MODE_RESET;
            mode_locked <= 1'b0;
        end else if (mode_write) begin
            mode        <= HWDATA;
            mode_locked <= 1'b1;
        end
    end

    // =================================================================
    // Halt conditions
    // Disable, debug halt and idle halt all freeze counter and divider
    assign halted = mode.timer_disable
                  | (mode.debug_halt & pin_sync.debug)
                  | (mode.idle_halt & pin_sync.idle);

    // =================================================================
    // Prescaler, divides slow clock edges by 128
    assign div_tick = slow_tick & ~halted
                    & (prescale == `WWDT_PRE_LAST);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            prescale <= '0;
        end else if (restart_ok || mode_write) begin
            prescale <= '0;
        end else if (slow_tick && !halted) begin
            prescale <= prescale + 7'h01;
        end
    end

    // =================================================================
    // Down counter
    // Underflow is the tick that finds the counter at zero; the count
    // then reloads so the watchdog keeps running after a fault
    assign underflow_evt = div_tick & (count == '0);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            count <= `WWDT_LOAD_RESET;
        end else if (mode_write) begin
            count <= HWDATA[`WWDT_CNT_W-1:0];
        end else if (restart_ok) begin
            count <= mode.counter_load_field;
        end else if (underflow_evt) begin
            count <= mode.counter_load_field;
        end else if (div_tick) begin
            count <= count - 12'h001;
        end
    end

    // =================================================================
    // Sticky status flags
    // An event in the cycle of the clearing read wins, so none is lost
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            underflow_flag <= 1'b0;
        end else if (underflow_evt) begin
            underflow_flag <= 1'b1;
        end else if (status_read) begin
            underflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            window_error_flag <= 1'b0;
        end else if (restart_err) begin
            window_error_flag <= 1'b1;
        end else if (status_read) begin
            window_error_flag <= 1'b0;
        end
    end

    // =================================================================
    // Fault level to the reset controller
    // Window errors always fault, even while disabled; underflow only
    // when the reset enable bit is set
    assign fault_set = restart_err
                     | (underflow_evt & mode.fault_reset_enable);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            FAULT <= 1'b0;
        end else if (fault_set) begin
            FAULT <= 1'b1;
        end else if (status_read) begin
            FAULT <= 1'b0;
        end
    end

    // =================================================================
    // Interrupt request
    // Follows the flags one cycle later, gated by the enable bit
    // A status read therefore withdraws it one cycle after the clear
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            FAULT_IRQ <= 1'b0;
        end else begin
            FAULT_IRQ <= mode.fault_interrupt_enable
                       & (underflow_flag | window_error_flag);
        end
    end

    // =================================================================
    // Reset requests
    // Follow the fault level one cycle later while reset enable is set; the controller answers
    // by pulling RST_N, which clears this whole block
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            RESET_ALL  <= 1'b0;
            RESET_PROC <= 1'b0;
        end else begin
            RESET_ALL  <= FAULT & mode.fault_reset_enable
                        & ~mode.processor_only_reset;
            RESET_PROC <= FAULT & mode.fault_reset_enable
                        & mode.processor_only_reset;
        end
    end

    // A restart shortly followed by a new delta or load value may end
    // a period early; software must space these by three slow clocks
    // since the window compare uses the live mode fields

endmodule : wwdt_top

// ==== sim/wwdt_far_end.sv ====
// Far side of the watchdog: slow oscillator and system reset controller
module wwdt_far_end (
    input  wire logic clk,        // System clock
    input  wire logic reset_all,  // Request for all resets
    input  wire logic reset_proc, // Request for processor reset
    output logic      slow_clk,   // Free-running slow clock
    output logic      wd_rst_n    // Reset given back to the watchdog
);
    timeunit 1ns;
    timeprecision 100ps;

    int hold; // Reset cycles still to give

    // ==========================================================
    // Oscillator: 40 ns period, each level lasts two and a half system clocks
    initial begin
        slow_clk = 1'b0;
        #3;
        forever #20 slow_clk = ~slow_clk;
    end

    // ==========================================================
    // Reset controller: any request resets processor and watchdog
    initial begin
        hold     = 0;
        wd_rst_n = 1'b1;
    end
    always @(posedge clk) begin
        if (reset_all || reset_proc) begin
            hold     <= 4;
            wd_rst_n <= 1'b0;
        end else begin
            // Long enough to flush the design's synchronisers
            hold     <= (hold > 0) ? hold - 1 : 0;
            wd_rst_n <= (hold == 0);
        end
    end
endmodule : wwdt_far_end

// ==== sim/wwdt_checker.sv ====
// Port-level assertions for the windowed watchdog
`include "wwdt_consts.svh"
module wwdt_checker (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic [31:0] HRDATA,
    input wire logic        FAULT,
    input wire logic        RESET_ALL,
    input wire logic        RESET_PROC
);
    logic        take;       // Address phase taken at this edge
    logic        rd_stat;    // Status read taken at this edge
    logic        dp_rd_ctl;  // Data phase of a control read
    logic        dp_rd_stat; // Data phase of a status read
    logic        dp_rd_mode; // Data phase of a mode read
    logic        dp_wr_mode; // Data phase of a mode write
    logic        locked;     // Mode written once already
    logic [31:0] mode_seen;  // Value of that first write

    assign take    = HSEL && HREADY && HTRANS[1];
    assign rd_stat = take && !HWRITE && (HADDR[7:0] == `WWDT_OFS_STATUS);

    // ==========================================================
    // Track which register each data phase belongs to
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            dp_rd_ctl  <= 1'b0;
            dp_rd_stat <= 1'b0;
            dp_rd_mode <= 1'b0;
            dp_wr_mode <= 1'b0;
        end else if (HREADY) begin
            dp_rd_ctl  <= take && !HWRITE && (HADDR[7:0] == `WWDT_OFS_CONTROL);
            dp_rd_stat <= rd_stat;
            dp_rd_mode <= take && !HWRITE && (HADDR[7:0] == `WWDT_OFS_MODE);
            dp_wr_mode <= take && HWRITE && (HADDR[7:0] == `WWDT_OFS_MODE);
        end
    end

    // ==========================================================
    // Only the first mode write after reset counts
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            locked    <= 1'b0;
            mode_seen <= 32'h0;
        end else if (dp_wr_mode && HREADY && !locked) begin
            locked    <= 1'b1;
            mode_seen <= HWDATA;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // ==========================================================
    // Assertions
    a_okay_resp: assert property (HRESP == 1'b0) else $error("error response given");
    a_ready_high: assert property ($past(RST_N) |-> HREADYOUT) else $error("wait state inserted");
    a_ctrl_zero: assert property (dp_rd_ctl |-> HRDATA == 32'h0) else $error("control read not zero");
    a_status_bits: assert property (dp_rd_stat |-> HRDATA[31:2] == 30'h0) else $error("status spare bits set");
    a_mode_reset: assert property (dp_rd_mode && !locked |-> HRDATA == `WWDT_MODE_RESET)
        else $error("mode reset value wrong");
    a_mode_once: assert property (dp_rd_mode && locked |-> HRDATA == mode_seen)
        else $error("mode not the first written value");
    a_read_clears: assert property (rd_stat && FAULT |=> !FAULT) else $error("status read left fault");
    a_fault_held: assert property ($fell(FAULT) |-> $past(rd_stat)) else $error("fault dropped unasked");
    a_req_cause: assert property (RESET_ALL || RESET_PROC |-> $past(FAULT))
        else $error("reset request without fault");
    a_scope_one: assert property (!(RESET_ALL && RESET_PROC)) else $error("both reset scopes asked");
endmodule : wwdt_checker

bind wwdt_top wwdt_checker chk_u (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .HRDATA(HRDATA), .FAULT(FAULT), .RESET_ALL(RESET_ALL), .RESET_PROC(RESET_PROC));

// ==== sim/tb_top.sv ====
// Self-checking bench for the windowed watchdog
`include "wwdt_consts.svh"
`define CHK(w, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s expected %h seen %h", w, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        CLK, tb_rst_n, HSEL, HWRITE, DEBUG_STATE, IDLE_MODE, locked_m, fault_m;
    logic [31:0] HADDR, HWDATA, q, mode_m; // Bus lines, read data, model mode
    logic [1:0]  HTRANS, flags_m;          // Model flags: bit0 underflow, bit1 error
    logic [2:0]  HSIZE;
    logic [7:0]  key;                      // Random wrong key
    wire         RST_N, SLOW_CLK, wd_rst_n, HREADYOUT, HRESP, FAULT, FAULT_IRQ, RESET_ALL, RESET_PROC;
    wire  [31:0] HRDATA;
    int          bad_count, comparisons, n, i;

    assign RST_N = tb_rst_n & wd_rst_n;

    wwdt_top dut_u (.CLK(CLK), .RST_N(RST_N), .SLOW_CLK(SLOW_CLK), .DEBUG_STATE(DEBUG_STATE),
        .IDLE_MODE(IDLE_MODE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
        .FAULT(FAULT), .FAULT_IRQ(FAULT_IRQ), .RESET_ALL(RESET_ALL), .RESET_PROC(RESET_PROC));
    wwdt_far_end far_u (.clk(CLK), .reset_all(RESET_ALL), .reset_proc(RESET_PROC), .slow_clk(SLOW_CLK),
        .wd_rst_n(wd_rst_n));

    // ==========================================================
    // Clock 125 MHz, and a watchdog against hangs
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    initial begin
        #400000;
        bad_count++;
        wrap_up();
    end

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // ==========================================================
    // One AHB-Lite single transfer; no wait count is assumed
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rdat);
        HSEL   <= 1'b1;
        HTRANS <= `WWDT_HTRANS_NONSEQ;
        HWRITE <= wr;
        HADDR  <= {24'h0, a};
        HSIZE  <= `WWDT_HSIZE_WORD;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HSEL   <= 1'b0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rdat = HRDATA;
    endtask : bus

    // Model state after any reset
    task automatic model_rst;
        mode_m   = `WWDT_MODE_RESET;
        locked_m = 1'b0;
        flags_m  = 2'h0;
        fault_m  = 1'b0;
    endtask : model_rst

    task automatic do_reset;
        tb_rst_n    <= 1'b0;
        DEBUG_STATE <= 1'b0;
        IDLE_MODE   <= 1'b0;
        repeat (10) @(posedge CLK);
        tb_rst_n <= 1'b1;
        repeat (2) @(posedge CLK);
        model_rst();
    endtask : do_reset

    // Read and compare; a status read empties the model flags
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
        bus(1'b0, a, 32'h0, q);
        `CHK(w, e, q)
        if (a == `WWDT_OFS_STATUS) begin
            flags_m = 2'h0;
            fault_m = 1'b0;
        end
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q);
        if (a == `WWDT_OFS_MODE && !locked_m) begin
            mode_m   = d;
            locked_m = 1'b1;
        end
    endtask : wr

    // Outputs predicted from the model
    task automatic model_chk;
        `CHK("fault", fault_m, FAULT)
        `CHK("irq", mode_m[12] & (flags_m != 2'h0), FAULT_IRQ)
        `CHK("reset all", fault_m & mode_m[13] & !mode_m[14], RESET_ALL)
        `CHK("reset proc", fault_m & mode_m[13] & mode_m[14], RESET_PROC)
    endtask : model_chk

    // Wait for interrupt (sel 0) or fault (sel 1), bounded
    task automatic wait_hi(input int sel, input int lim);
        n = 0;
        while (((sel == 0) ? FAULT_IRQ : FAULT) !== 1'b1 && n < lim) begin
            @(posedge CLK);
            n++;
        end
    endtask : wait_hi

    // Mode word; b: 0 irq en, 1 reset en, 2 proc only, 3 disable, 4 debug halt, 5 idle halt
    function automatic logic [31:0] mk(input logic [11:0] ld, input logic [11:0] dl, input logic [7:0] b);
        return {2'b00, b[5:4], dl, b[3:0], ld};
    endfunction : mk

    // ==========================================================
    // Main sequence
    initial begin
        {tb_rst_n, HSEL, HWRITE, DEBUG_STATE, IDLE_MODE} = 5'h0;
        {HADDR, HWDATA, HTRANS, HSIZE} = 69'h0;
        bad_count   = 0;
        comparisons = 0;
        void'($urandom(82836));
        do_reset();
        rd(`WWDT_OFS_MODE, `WWDT_MODE_RESET, "mode reset");
        rd(`WWDT_OFS_CONTROL, 32'h0, "control read");
        rd(8'h0c, 32'h0, "unmapped read");
        wr(`WWDT_OFS_CONTROL, 32'ha5000001);
        rd(`WWDT_OFS_STATUS, 32'h0, "default restart");
        model_chk();
        // Narrow window: load 3, delta 1, interrupt only
        wr(`WWDT_OFS_MODE, mk(12'h003, 12'h001, 8'h01));
        wr(`WWDT_OFS_MODE, mk(12'h0ff, 12'h0ff, 8'h02));
        rd(`WWDT_OFS_MODE, mode_m, "mode once");
        for (i = 0; i < 4; i++) begin
            key = 8'($urandom_range(255));
            wr(`WWDT_OFS_CONTROL, {(key == 8'ha5) ? 8'h5a : key, 24'h000001});
        end
        wr(`WWDT_OFS_CONTROL, 32'ha5000000);
        rd(`WWDT_OFS_STATUS, 32'h0, "void restart");
        wr(`WWDT_OFS_CONTROL, 32'ha5000001);
        flags_m = 2'h2;
        fault_m = 1'b1;
        repeat (2) @(posedge CLK);
        model_chk();
        rd(`WWDT_OFS_STATUS, 32'h2, "window error");
        repeat (2) @(posedge CLK);
        model_chk();
        // Count now at 1, inside the window: restart, then four ticks of 640 clocks
        repeat (1600) @(posedge CLK);
        wr(`WWDT_OFS_CONTROL, 32'ha5000001);
        repeat (2540) @(posedge CLK);
        model_chk();
        wait_hi(0, 60);
        flags_m = 2'h1;
        model_chk();
        repeat (700) @(posedge CLK);
        model_chk();
        rd(`WWDT_OFS_STATUS, 32'h1, "underflow");
        repeat (2) @(posedge CLK);
        model_chk();
        // Underflow with reset enabled, both scopes, then the watchdog reset
        for (i = 0; i < 2; i++) begin
            do_reset();
            wr(`WWDT_OFS_MODE, mk(12'h000, 12'hfff, (i == 0) ? 8'h02 : 8'h06));
            wait_hi(1, 800);
            `CHK("tick span", 1'b1, (n > 620 && n < 660))
            fault_m = 1'b1;
            flags_m = 2'h1;
            @(posedge CLK);
            model_chk();
            repeat (20) @(posedge CLK);
            model_rst();
            rd(`WWDT_OFS_MODE, `WWDT_MODE_RESET, "mode after reset");
            rd(`WWDT_OFS_STATUS, 32'h0, "status after reset");
            model_chk();
        end
        // Disable, debug halt and idle halt each freeze the count
        for (i = 0; i < 3; i++) begin
            do_reset();
            DEBUG_STATE <= (i == 1);
            IDLE_MODE   <= (i == 2);
            wr(`WWDT_OFS_MODE, mk(12'h001, 12'h000, (i == 0) ? 8'h09 : ((i == 1) ? 8'h11 : 8'h21)));
            repeat (1500) @(posedge CLK);
            model_chk();
            if (i == 0) begin
                wr(`WWDT_OFS_CONTROL, 32'ha5000001);
                flags_m = 2'h2;
                fault_m = 1'b1;
                repeat (2) @(posedge CLK);
                model_chk();
            end else begin
                DEBUG_STATE <= 1'b0;
                IDLE_MODE   <= 1'b0;
                wait_hi(0, 1500);
                flags_m = 2'h1;
                model_chk();
            end
        end
        wrap_up();
    end
endmodule : tb_top
